// ---- core/packet_capture.sv ----
// Packet capture: stores the bytes of one command packet and reports its size.
// Assumes the caller only takes bytes while it is ready to decode them.
`timescale 1ns/100ps
`default_nettype none
module packet_capture #(
	parameter int MAX_BYTES = superpacket_pkg::CAPTURE_BYTES
) (
	// Clock and reset.
	input  wire logic                   i_core_clk,
	input  wire logic                   i_rst_n,
	// Byte stream.
	input  wire logic                   i_take,
	input  wire logic [7:0]             i_data,
	input  wire logic                   i_last,
	// Captured packet.
	output logic                        o_done,
	output logic [5:0]                  o_count,
	output logic                        o_overflow,
	output logic [8*MAX_BYTES-1:0]      o_bytes
);
	import superpacket_pkg::*;

	logic [7:0] mem_q [MAX_BYTES];
	logic [5:0] count_q;
	logic       ovf_q;

	// ------------------------------------------------------------
	// Byte store
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (i_take && (count_q < 6'(MAX_BYTES))) begin
			mem_q[count_q] <= i_data;
		end
	end

	// ------------------------------------------------------------
	// Count, overflow and completion
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			count_q    <= 6'h00;
			ovf_q      <= 1'b0;
			o_done     <= 1'b0;
			o_count    <= 6'h00;
			o_overflow <= 1'b0;
		end else begin
			o_done <= i_take && i_last;
			if (i_take) begin
				if (i_last) begin
					count_q    <= 6'h00;
					ovf_q      <= 1'b0;
					o_count    <= (count_q < 6'(MAX_BYTES)) ? count_q + 6'h01 : count_q;
					o_overflow <= ovf_q || (count_q >= 6'(MAX_BYTES));
				end else if (count_q < 6'(MAX_BYTES)) begin
					count_q <= count_q + 6'h01;
				end else begin
					ovf_q <= 1'b1;
				end
			end
		end
	end

	genvar g;
	generate
		for (g = 0; g < MAX_BYTES; g++) begin : g_flat
			assign o_bytes[8*g +: 8] = mem_q[g];
		end
	endgenerate

endmodule
`default_nettype wire

// ---- core/superpacket_decoder.sv ----
// Superpacket command decoder: executes host commands and builds reports.
// Assumes framed, unstuffed packets on the same clock; a datum table ROM
// answers combinationally within one cycle.
//
// What this block does
// - Port report first byte: 0 or 1.
// - Baud codes 0-9, data bits 2/3, parity 0-2.
// - Stop bits coded 0 or 2.
// - Flow control is OR of option bits.
// - First data byte selects extended sub-code.
// - Extended identifier is code then sub-code.
// - Datum sub-code alone returns datum report.
// - Two-byte index selects one of 180 datums.
// - Custom datum takes five doubles, bytes 1-40.
// - Custom datum values stored without checks.
// - Datum change feeds all position outputs.
// - Latest variant keeps only default datum.
// - Grid enable by 0x45; precision picks report.
// - Compact fix sub-code alone requests report.
// - Second byte 1 marks, 0 unmarks auto.
// - Auto output needs extended output enabled.
// - Poll 0x37 sends fix when auto.
// - Save, then report only after completion.
// - Datum report: sub-code, index, five doubles.
`timescale 1ns/100ps
`default_nettype none
module superpacket_decoder #(
	parameter bit LATEST_FW = 1'b0
) (
	// Clock and reset.
	input  wire logic        i_core_clk,
	input  wire logic        i_rst_n,
	// Command byte stream.
	input  wire logic        i_rx_valid,
	input  wire logic [7:0]  i_rx_data,
	input  wire logic        i_rx_last,
	output logic             o_rx_ready,
	// Report byte stream.
	output logic             o_tx_valid,
	output logic [7:0]       o_tx_data,
	output logic             o_tx_last,
	input  wire logic        i_tx_ready,
	// Serial port configuration being described.
	input  wire logic        i_cur_port,
	output logic             o_cfg_port,
	input  wire logic [3:0]  i_cfg_in_baud,
	input  wire logic [3:0]  i_cfg_out_baud,
	input  wire logic        i_cfg_data8,
	input  wire logic [1:0]  i_cfg_parity,
	input  wire logic        i_cfg_two_stop,
	input  wire logic        i_cfg_rts_cts,
	input  wire logic        i_cfg_tx_xon,
	input  wire logic        i_cfg_tx_xany,
	input  wire logic        i_cfg_rx_xon,
	input  wire logic [7:0]  i_cfg_in_proto,
	input  wire logic [7:0]  i_cfg_out_proto,
	// I/O options.
	input  wire logic        i_io_double,
	input  wire logic        i_io_ext_out_en,
	// Datum table and datum in use.
	output logic [7:0]       o_table_index,
	output logic [5:0]       o_table_byte,
	input  wire logic [7:0]  i_table_data,
	output logic [15:0]      o_datum_index,
	output logic             o_datum_change,
	output logic [63:0]      o_datum_offset_x,
	output logic [63:0]      o_datum_offset_y,
	output logic [63:0]      o_datum_offset_z,
	output logic [63:0]      o_datum_axis,
	output logic [63:0]      o_datum_ecc_sq,
	// Report controls.
	output logic             o_grid_report_enable_flag,
	output logic             o_grid_single_en,
	output logic             o_grid_double_en,
	output logic             o_fix_report_req,
	output logic             o_fix_auto_en,
	// Non-volatile save.
	output logic             o_save_req,
	input  wire logic        i_save_done
);
	import superpacket_pkg::*;

	localparam int PAY_W = 8 * CAPTURE_BYTES;

	function automatic logic [7:0] pay_byte(input logic [PAY_W-1:0] flat, input int k);
		pay_byte = flat[8*k +: 8];
	endfunction

	state_t           state_q;
	state_t           state_d;
	rpt_kind_t        kind_q;
	logic [5:0]       tx_idx_q;
	logic [5:0]       rpt_len;
	logic [7:0]       rpt_byte;
	logic             take;
	logic             cap_done;
	logic [5:0]       cap_count;
	logic             cap_ovf;
	logic [PAY_W-1:0] pay;
	logic [7:0]       code;
	logic [7:0]       sub;
	logic [7:0]       arg;
	logic [15:0]      idx_val;
	logic             dat_query;
	logic             dat_index;
	logic             dat_custom;
	logic             grid_set;
	logic             fix_query;
	logic             fix_mark;
	logic             save_cmd;
	logic             fix_poll;
	logic             port_query;
	logic             bad;
	logic             exec;
	logic             mark_q;
	logic             port_sel_q;
	logic [319:0]     datum_val_q;

	assign take = i_rx_valid && o_rx_ready;
	assign exec = (state_q == ST_EXEC);

	packet_capture #(
		.MAX_BYTES (CAPTURE_BYTES)
	) u_capture (
		.i_core_clk (i_core_clk),
		.i_rst_n    (i_rst_n),
		.i_take     (take),
		.i_data     (i_rx_data),
		.i_last     (i_rx_last),
		.o_done     (cap_done),
		.o_count    (cap_count),
		.o_overflow (cap_ovf),
		.o_bytes    (pay)
	);

	// ------------------------------------------------------------
	// Command decode
	// ------------------------------------------------------------
	always_comb begin
		code    = pay_byte(pay, 0);
		sub     = pay_byte(pay, 1);
		arg     = pay_byte(pay, 2);
		idx_val = {pay_byte(pay, 2), pay_byte(pay, 3)};
		dat_query  = 1'b0;
		dat_index  = 1'b0;
		dat_custom = 1'b0;
		grid_set   = 1'b0;
		fix_query  = 1'b0;
		fix_mark   = 1'b0;
		save_cmd   = 1'b0;
		fix_poll   = 1'b0;
		port_query = 1'b0;
		bad        = 1'b0;
		if (cap_ovf) begin
			bad = 1'b1;
		end else if (code == CODE_EXT_CMD) begin
			unique case (sub)
				SUB_DATUM: begin
					dat_query  = (cap_count == LEN_SUB_ONLY + 6'h01);
					dat_index  = (cap_count == LEN_DATUM_INDEX + 6'h01) && (idx_val < DATUM_COUNT);
					dat_custom = (cap_count == LEN_DATUM_CUSTOM + 6'h01);
				end
				SUB_GRID:  grid_set  = (cap_count == LEN_SUB_BYTE + 6'h01);
				SUB_FIX: begin
					fix_query = (cap_count == LEN_SUB_ONLY + 6'h01);
					// only 0 or 1 are marks
					fix_mark  = (cap_count == LEN_SUB_BYTE + 6'h01) && (arg[7:1] == 7'h00);
				end
				SUB_SAVE:  save_cmd  = (cap_count == LEN_SUB_ONLY + 6'h01);
				default:   bad = 1'b1;
			endcase
			if (!(dat_query || dat_index || dat_custom || grid_set || fix_query
			      || fix_mark || save_cmd)) begin
				bad = 1'b1;
			end
		end else if (code == CODE_POLL_FIX) begin
			fix_poll = 1'b1;
		end else if (code == CODE_PORT) begin
			port_query = (cap_count == 6'h02) && ((sub[7:1] == 7'h00) || (sub == PORT_CURRENT));
		end
	end

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_IDLE: if (cap_done) state_d = ST_EXEC;
			ST_EXEC: begin
				if (dat_query || port_query) begin
					state_d = ST_TX_ADDR;
				end else if (save_cmd) begin
					state_d = ST_SAVE_WAIT;
				end else begin
					state_d = ST_IDLE;
				end
			end
			ST_SAVE_WAIT: if (i_save_done) state_d = ST_TX_ADDR;
			ST_TX_ADDR: state_d = ST_TX_LOAD;
			ST_TX_LOAD: state_d = ST_TX_WAIT;
			ST_TX_WAIT: begin
				if (i_tx_ready) begin
					state_d = o_tx_last ? ST_IDLE : ST_TX_ADDR;
				end
			end
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			state_q    <= ST_IDLE;
			o_rx_ready <= 1'b0;
		end else begin
			state_q    <= state_d;
			o_rx_ready <= (state_d == ST_IDLE) && !(take && i_rx_last) && !cap_done;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			kind_q     <= RPT_SAVE;
			tx_idx_q   <= 6'h00;
			port_sel_q <= 1'b0;
			o_cfg_port <= 1'b0;
		end else begin
			if (exec) begin
				tx_idx_q <= 6'h00;
				if (dat_query) begin
					kind_q <= RPT_DATUM;
				end else if (port_query) begin
					kind_q     <= RPT_PORT;
					port_sel_q <= (sub == PORT_CURRENT) ? i_cur_port : sub[0];
					o_cfg_port <= (sub == PORT_CURRENT) ? i_cur_port : sub[0];
				end else if (save_cmd) begin
					kind_q <= RPT_SAVE;
				end
			end else if (state_q == ST_TX_WAIT && i_tx_ready) begin
				tx_idx_q <= tx_idx_q + 6'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// Report bytes
	// ------------------------------------------------------------
	always_comb begin
		rpt_byte = 8'h00;
		rpt_len  = RPT_SAVE_LEN;
		unique case (kind_q)
			RPT_DATUM: begin
				rpt_len = RPT_DATUM_LEN;
				if (tx_idx_q == 6'h00) rpt_byte = CODE_EXT_RPT;
				else if (tx_idx_q == 6'h01) rpt_byte = SUB_DATUM;
				else if (tx_idx_q == 6'h02) rpt_byte = o_datum_index[15:8];
				else if (tx_idx_q == 6'h03) rpt_byte = o_datum_index[7:0];
				else if (o_datum_index == DATUM_INDEX_CUSTOM) begin
					rpt_byte = datum_val_q[319 - 8*int'(o_table_byte) -: 8];
				end else begin
					rpt_byte = i_table_data;
				end
			end
			RPT_PORT: begin
				rpt_len = RPT_PORT_LEN;
				unique case (tx_idx_q)
					6'h00: rpt_byte = CODE_PORT;
					6'h01: rpt_byte = {7'h00, port_sel_q};
					6'h02: rpt_byte = ({4'h0, i_cfg_in_baud} > BAUD_CODE_MAX) ? 8'h00 : {4'h0, i_cfg_in_baud};
					6'h03: rpt_byte = ({4'h0, i_cfg_out_baud} > BAUD_CODE_MAX) ? 8'h00 : {4'h0, i_cfg_out_baud};
					6'h04: rpt_byte = i_cfg_data8 ? DATA_BITS_8 : DATA_BITS_7;
					6'h05: rpt_byte = ({6'h00, i_cfg_parity} > PARITY_MAX) ? 8'h00 : {6'h00, i_cfg_parity};
					6'h06: rpt_byte = i_cfg_two_stop ? STOP_BITS_2 : STOP_BITS_1;
					6'h07: rpt_byte = {4'h0, i_cfg_rx_xon, i_cfg_tx_xany, i_cfg_tx_xon, i_cfg_rts_cts};
					6'h08: rpt_byte = i_cfg_in_proto;
					6'h09: rpt_byte = i_cfg_out_proto;
					default: rpt_byte = 8'h00;
				endcase
			end
			RPT_SAVE: rpt_byte = (tx_idx_q == 6'h00) ? CODE_EXT_RPT : SUB_SAVE;
		endcase
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_tx_valid    <= 1'b0;
			o_tx_data     <= 8'h00;
			o_tx_last     <= 1'b0;
			o_table_index <= 8'h00;
			o_table_byte  <= 6'h00;
		end else begin
			if (state_q == ST_TX_ADDR) begin
				o_table_index <= o_datum_index[7:0];
				o_table_byte  <= tx_idx_q - RPT_DATUM_HEAD;
			end
			if (state_q == ST_TX_LOAD) begin
				o_tx_valid <= 1'b1;
				o_tx_data  <= rpt_byte;
				o_tx_last  <= (tx_idx_q == rpt_len - 6'h01);
			end else if (state_q == ST_TX_WAIT && i_tx_ready) begin
				o_tx_valid <= 1'b0;
				o_tx_last  <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// Datum store
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_datum_index  <= DATUM_INDEX_DEFAULT;
			o_datum_change <= 1'b0;
			datum_val_q    <= '0;
		end else begin
			o_datum_change <= 1'b0;
			if (exec && !LATEST_FW) begin
				if (dat_index) begin
					o_datum_index  <= idx_val;
					o_datum_change <= 1'b1;
				end else if (dat_custom) begin
					o_datum_index  <= DATUM_INDEX_CUSTOM;
					o_datum_change <= 1'b1;
					for (int k = 0; k < DATUM_VAL_BYTES; k++) begin
						datum_val_q[319 - 8*k -: 8] <= pay_byte(pay, k + DATUM_VAL_FIRST);
					end
				end
			end
		end
	end

	assign o_datum_offset_x = datum_val_q[319:256];
	assign o_datum_offset_y = datum_val_q[255:192];
	assign o_datum_offset_z = datum_val_q[191:128];
	assign o_datum_axis     = datum_val_q[127:64];
	assign o_datum_ecc_sq   = datum_val_q[63:0];

	// ------------------------------------------------------------
	// Grid, compact fix and save controls
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			o_grid_report_enable_flag <= 1'b0;
			o_grid_single_en          <= 1'b0;
			o_grid_double_en          <= 1'b0;
		end else begin
			if (exec && grid_set) begin
				o_grid_report_enable_flag <= (arg == GRID_ENABLE_CHAR);
			end
			o_grid_single_en <= o_grid_report_enable_flag && !i_io_double;
			o_grid_double_en <= o_grid_report_enable_flag && i_io_double;
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			mark_q           <= 1'b0;
			o_fix_auto_en    <= 1'b0;
			o_fix_report_req <= 1'b0;
			o_save_req       <= 1'b0;
		end else begin
			if (exec && fix_mark) begin
				mark_q <= arg[0];
			end
			o_fix_auto_en <= mark_q && i_io_ext_out_en;
			o_fix_report_req <= exec && (fix_query || (fix_poll && mark_q && i_io_ext_out_en));
			o_save_req <= exec && save_cmd;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	a_ready_when_busy: assert property ((state_q != ST_IDLE) |-> !o_rx_ready)
		else $error("ready raised while a packet is in work");
	a_datum_query_rpt: assert property (exec && dat_query |=> kind_q == RPT_DATUM ##2 o_tx_valid)
		else $error("datum query did not start a datum report");
	a_custom_index: assert property (exec && dat_custom && !LATEST_FW |=> o_datum_index == 16'hFFFF && o_datum_change)
		else $error("custom datum did not set index minus one");
	a_latest_default: assert property (exec && (dat_index || dat_custom) |=> (o_datum_change != LATEST_FW)
		&& (!LATEST_FW || o_datum_index == DATUM_INDEX_DEFAULT))
		else $error("latest variant left the default datum");
	a_grid_enable: assert property (exec && grid_set && arg == 8'h45 |=> o_grid_report_enable_flag ##1 (o_grid_double_en == $past(i_io_double)))
		else $error("grid enable did not select by precision");
	a_fix_query: assert property (exec && fix_query |=> o_fix_report_req ##1 !o_fix_report_req)
		else $error("compact fix query not answered once");
	a_fix_gate: assert property ((o_fix_auto_en || (o_fix_report_req && !$past(fix_query)))
		|-> $past(mark_q) && $past(i_io_ext_out_en))
		else $error("auto fix output without extended output");
	a_poll_fix: assert property (exec && fix_poll && mark_q && i_io_ext_out_en |=> o_fix_report_req)
		else $error("poll did not request the compact fix");
	a_save_wait: assert property (state_q == ST_SAVE_WAIT && !i_save_done |=> state_q == ST_SAVE_WAIT && !o_tx_valid)
		else $error("save report left before storing ended");
	a_discard_bad: assert property (exec && bad |=> $stable(datum_val_q) && $stable(o_datum_index) && $stable(mark_q) && state_q == ST_IDLE)
		else $error("discarded command changed a setting");
	a_port_code: assert property (o_tx_valid && kind_q == RPT_PORT && tx_idx_q == 6'h01 |-> o_tx_data[7:1] == 7'h00)
		else $error("port report carries a bad port code");

endmodule
`default_nettype wire

// ---- core/superpacket_pkg.sv ----
// Constants shared by the superpacket command decoder and its packet capture.
// Assumes byte-level packets with framing and byte stuffing already removed.
package superpacket_pkg;

	// Packet codes and sub-codes.
	localparam logic [7:0] CODE_EXT_CMD     = 8'h8E;
	localparam logic [7:0] CODE_EXT_RPT     = 8'h8F;
	localparam logic [7:0] CODE_PORT        = 8'hBC;
	localparam logic [7:0] CODE_POLL_FIX    = 8'h37;
	localparam logic [7:0] SUB_DATUM        = 8'h15;
	localparam logic [7:0] SUB_GRID         = 8'h19;
	localparam logic [7:0] SUB_FIX          = 8'h20;
	localparam logic [7:0] SUB_SAVE         = 8'h26;
	localparam logic [7:0] GRID_ENABLE_CHAR = 8'h45;
	localparam logic [7:0] PORT_CURRENT     = 8'hFF;

	// Data byte counts (sub-code included) of each accepted form.
	localparam logic [5:0] LEN_SUB_ONLY     = 6'h01;
	localparam logic [5:0] LEN_SUB_BYTE     = 6'h02;
	localparam logic [5:0] LEN_DATUM_INDEX  = 6'h03;
	localparam logic [5:0] LEN_DATUM_CUSTOM = 6'h29;

	// Packet capture depth: packet code plus the longest payload.
	localparam int CAPTURE_BYTES = 42;

	// Datum store and report layout.
	localparam logic [15:0] DATUM_COUNT         = 16'h00B4;
	localparam logic [15:0] DATUM_INDEX_DEFAULT = 16'h0000;
	localparam logic [15:0] DATUM_INDEX_CUSTOM  = 16'hFFFF;
	localparam int          DATUM_VAL_BYTES     = 40;
	localparam int          DATUM_VAL_FIRST     = 2;
	localparam logic [5:0]  RPT_DATUM_HEAD      = 6'h04;

	// Report lengths in bytes, packet code included.
	localparam logic [5:0] RPT_DATUM_LEN = 6'h2C;
	localparam logic [5:0] RPT_PORT_LEN  = 6'h0B;
	localparam logic [5:0] RPT_SAVE_LEN  = 6'h02;

	// Port report field codes.
	localparam logic [7:0] BAUD_CODE_MAX  = 8'h09;
	localparam logic [7:0] DATA_BITS_7    = 8'h02;
	localparam logic [7:0] DATA_BITS_8    = 8'h03;
	localparam logic [7:0] STOP_BITS_1    = 8'h00;
	localparam logic [7:0] STOP_BITS_2    = 8'h02;
	localparam logic [7:0] PARITY_MAX     = 8'h02;

	typedef enum {
		ST_IDLE,
		ST_EXEC,
		ST_SAVE_WAIT,
		ST_TX_ADDR,
		ST_TX_LOAD,
		ST_TX_WAIT
	} state_t;

	typedef enum {
		RPT_DATUM,
		RPT_PORT,
		RPT_SAVE
	} rpt_kind_t;

endpackage

// ---- test/host_side_model.sv ----
// Model of the parties beyond the decoder: datum table, settings store, report sink.
// Assumes the decoder's clock and synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none
module host_side_model (
	// Clock and reset.
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_n,
	// Datum table, settings store and report sink.
	input  wire logic [7:0] i_table_index,
	input  wire logic [5:0] i_table_byte,
	input  wire logic       i_save_req,
	output logic [7:0]      o_table_data,
	output logic            o_save_done,
	output logic            o_tx_ready
);
	logic [3:0] save_cnt_q;
	logic [1:0] stall_q;

	assign o_table_data = i_table_index + {2'h0, i_table_byte};

	always_ff @(posedge i_core_clk) begin
		if (!i_rst_n) begin
			save_cnt_q <= 4'h0;
		end else if (i_save_req) begin
			save_cnt_q <= 4'h6;
		end else if (save_cnt_q != 4'h0) begin
			save_cnt_q <= save_cnt_q - 4'h1;
		end
	end
	assign o_save_done = (save_cnt_q == 4'h1);

	// The sink stalls one cycle in four.
	always_ff @(posedge i_core_clk) begin
		stall_q <= i_rst_n ? stall_q + 2'h1 : 2'h0;
	end
	assign o_tx_ready = (stall_q != 2'h0);
endmodule
`default_nettype wire

// ---- test/superpacket_decoder_tb_top.sv ----
// Self-checking bench for the superpacket command decoder.
// Assumes the host side model answers table, storage and report sink.
`timescale 1ns/100ps
`default_nettype none
module superpacket_decoder_tb_top;
	import superpacket_pkg::*;
	logic        i_core_clk = 1'b0;
	logic        i_rst_n = 1'b0;
	logic        i_rx_valid = 1'b0;
	logic [7:0]  i_rx_data = 8'h00;
	logic        i_rx_last = 1'b0;
	logic        i_cur_port = 1'b0;
	logic [3:0]  i_cfg_in_baud = 4'h0;
	logic [3:0]  i_cfg_out_baud = 4'h0;
	logic        i_cfg_data8 = 1'b0;
	logic [1:0]  i_cfg_parity = 2'h0;
	logic        i_cfg_two_stop = 1'b0;
	logic        i_cfg_rts_cts = 1'b0;
	logic        i_cfg_tx_xon = 1'b0;
	logic        i_cfg_tx_xany = 1'b0;
	logic        i_cfg_rx_xon = 1'b0;
	logic [7:0]  i_cfg_in_proto = 8'h00;
	logic [7:0]  i_cfg_out_proto = 8'h00;
	logic        i_io_double = 1'b0;
	logic        i_io_ext_out_en = 1'b0;
	wire logic   i_tx_ready, i_save_done, o_rx_ready, o_tx_valid, o_tx_last, o_cfg_port;
	wire logic   o_datum_change, o_grid_report_enable_flag, o_grid_single_en;
	wire logic   o_grid_double_en, o_fix_report_req, o_fix_auto_en, o_save_req;
	wire logic [7:0]  i_table_data, o_tx_data, o_table_index;
	wire logic [5:0]  o_table_byte;
	wire logic [15:0] o_datum_index;
	wire logic [63:0] o_datum_offset_x, o_datum_offset_y, o_datum_offset_z;
	wire logic [63:0] o_datum_axis, o_datum_ecc_sq;
	int          err_count = 0;
	int          comparisons = 0;
	int          fix_n = 0;
	int          save_n = 0;
	int          chg_n = 0;

	superpacket_decoder i_dut (.i_core_clk, .i_rst_n, .i_rx_valid, .i_rx_data, .i_rx_last,
		.o_rx_ready, .o_tx_valid, .o_tx_data, .o_tx_last, .i_tx_ready, .i_cur_port,
		.o_cfg_port, .i_cfg_in_baud, .i_cfg_out_baud, .i_cfg_data8, .i_cfg_parity,
		.i_cfg_two_stop, .i_cfg_rts_cts, .i_cfg_tx_xon, .i_cfg_tx_xany, .i_cfg_rx_xon,
		.i_cfg_in_proto, .i_cfg_out_proto, .i_io_double, .i_io_ext_out_en, .o_table_index,
		.o_table_byte, .i_table_data, .o_datum_index, .o_datum_change, .o_datum_offset_x,
		.o_datum_offset_y, .o_datum_offset_z, .o_datum_axis, .o_datum_ecc_sq,
		.o_grid_report_enable_flag, .o_grid_single_en, .o_grid_double_en,
		.o_fix_report_req, .o_fix_auto_en, .o_save_req, .i_save_done);

	host_side_model i_host (.i_core_clk, .i_rst_n, .i_table_index(o_table_index),
		.i_table_byte(o_table_byte), .i_save_req(o_save_req), .o_table_data(i_table_data),
		.o_save_done(i_save_done), .o_tx_ready(i_tx_ready));

	initial begin
		forever #50 i_core_clk = ~i_core_clk;
	end

	// Counts the one-cycle control pulses.
	always @(posedge i_core_clk) begin
		fix_n += (o_fix_report_req === 1'b1);
		save_n += (o_save_req === 1'b1);
		chg_n += (o_datum_change === 1'b1);
	end

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %0h seen %0h", what, exp, seen);
		end
	endtask

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	task automatic send(input logic [7:0] b[$]);
		int n;
		foreach (b[k]) begin
			i_rx_valid = 1'b1;
			i_rx_data = b[k];
			i_rx_last = (k == b.size() - 1);
			n = 0;
			do begin
				@(posedge i_core_clk);
				n++;
			end while (o_rx_ready !== 1'b1 && n < 300);
			if (o_rx_ready !== 1'b1) err_count++;
			#1;
		end
		i_rx_valid = 1'b0;
		i_rx_last = 1'b0;
	endtask

	task automatic idle;
		int n;
		n = 0;
		do begin
			@(posedge i_core_clk);
			#1;
			n++;
		end while (o_rx_ready !== 1'b1 && n < 300);
		if (o_rx_ready !== 1'b1) err_count++;
		@(posedge i_core_clk);
		#1;
	endtask

	task automatic rpt(input logic [7:0] e[$]);
		int n;
		foreach (e[k]) begin
			n = 0;
			do begin
				@(posedge i_core_clk);
				n++;
			end while (!(o_tx_valid === 1'b1 && i_tx_ready === 1'b1) && n < 300);
			if (o_tx_valid !== 1'b1 || i_tx_ready !== 1'b1) err_count++;
			chk("report byte", o_tx_data, e[k]);
			chk("report last", o_tx_last, k == e.size() - 1);
		end
		#1;
	endtask

	function automatic logic [7:0] rom(input logic [7:0] i, input logic [5:0] b);
		return i + {2'h0, b};
	endfunction

	task automatic q_datum(input logic [15:0] idx);
		logic [7:0] e[$];
		e = {8'h8F, 8'h15, idx[15:8], idx[7:0]};
		for (int b = 0; b < 40; b++) begin
			e.push_back(idx === 16'hFFFF ? 8'hC0 + 8'(b) : rom(idx[7:0], 6'(b)));
		end
		send({8'h8E, 8'h15});
		rpt(e);
		idle();
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_port;
		i_cfg_in_baud = 4'h9;
		i_cfg_out_baud = 4'hA;
		i_cfg_parity = 2'h2;
		i_cfg_rts_cts = 1'b1;
		i_cfg_rx_xon = 1'b1;
		i_cfg_in_proto = 8'h1F;
		i_cfg_out_proto = 8'h04;
		send({8'hBC, 8'h00});
		rpt({8'hBC, 8'h00, 8'h09, 8'h00, 8'h02, 8'h02, 8'h00, 8'h09, 8'h1F, 8'h04, 8'h00});
		idle();
		i_cur_port = 1'b1;
		i_cfg_in_baud = 4'h1;
		i_cfg_out_baud = 4'h9;
		i_cfg_data8 = 1'b1;
		i_cfg_parity = 2'h3;
		i_cfg_two_stop = 1'b1;
		i_cfg_tx_xon = 1'b1;
		i_cfg_tx_xany = 1'b1;
		i_cfg_in_proto = 8'h00;
		i_cfg_out_proto = 8'h13;
		send({8'hBC, 8'hFF});
		rpt({8'hBC, 8'h01, 8'h01, 8'h09, 8'h03, 8'h00, 8'h02, 8'h0F, 8'h00, 8'h13, 8'h00});
		idle();
		chk("port selected", o_cfg_port, 1'b1);
		$display("test port done");
	endtask

	task automatic t_datum;
		logic [7:0] q[$];
		q_datum(16'h0000);
		send({8'h8E, 8'h15, 8'h00, 8'h05});
		idle();
		chk("datum index", o_datum_index, 16'h0005);
		chk("datum change", chg_n, 1);
		send({8'h8E, 8'h15, 8'h00, 8'hB4});
		idle();
		send({8'h8E, 8'h15, 8'h00});
		idle();
		chk("bad index kept", o_datum_index, 16'h0005);
		q_datum(16'h0005);
		q = {8'h8E, 8'h15};
		for (int b = 0; b < 40; b++) begin
			q.push_back(8'hC0 + 8'(b));
		end
		send(q);
		idle();
		chk("custom index", o_datum_index, 16'hFFFF);
		chk("offset x", o_datum_offset_x, 64'hC0C1C2C3C4C5C6C7);
		chk("offset y", o_datum_offset_y, 64'hC8C9CACBCCCDCECF);
		chk("offset z", o_datum_offset_z, 64'hD0D1D2D3D4D5D6D7);
		chk("axis", o_datum_axis, 64'hD8D9DADBDCDDDEDF);
		chk("ecc sq", o_datum_ecc_sq, 64'hE0E1E2E3E4E5E6E7);
		chk("datum change", chg_n, 2);
		q_datum(16'hFFFF);
		$display("test datum done");
	endtask

	task automatic t_grid;
		i_io_double = 1'b1;
		send({8'h8E, 8'h19, 8'h45});
		idle();
		chk("grid flag", o_grid_report_enable_flag, 1'b1);
		chk("grid double", o_grid_double_en, 1'b1);
		chk("grid single", o_grid_single_en, 1'b0);
		i_io_double = 1'b0;
		idle();
		chk("grid single", o_grid_single_en, 1'b1);
		send({8'h8E, 8'h19, 8'h44});
		idle();
		chk("grid flag", o_grid_report_enable_flag, 1'b0);
		$display("test grid done");
	endtask

	task automatic t_fix;
		send({8'h8E, 8'h20});
		idle();
		chk("fix request", fix_n, 1);
		i_io_ext_out_en = 1'b1;
		send({8'h8E, 8'h20, 8'h01});
		idle();
		chk("auto mark", o_fix_auto_en, 1'b1);
		send({8'h37});
		idle();
		chk("poll sends", fix_n, 2);
		i_io_ext_out_en = 1'b0;
		send({8'h37});
		idle();
		chk("poll no ext", fix_n, 2);
		chk("auto no ext", o_fix_auto_en, 1'b0);
		i_io_ext_out_en = 1'b1;
		send({8'h8E, 8'h20, 8'h00});
		idle();
		send({8'h37});
		idle();
		chk("poll unmarked", fix_n, 2);
		send({8'h8E, 8'h20, 8'h03});
		idle();
		chk("bad mark", o_fix_auto_en, 1'b0);
		$display("test fix done");
	endtask

	task automatic t_save;
		int  n;
		bit  early;
		early = 1'b0;
		n = 0;
		send({8'h8E, 8'h26});
		while (i_save_done !== 1'b1 && n < 50) begin
			@(posedge i_core_clk);
			early |= (o_tx_valid !== 1'b0);
			n++;
		end
		#1;
		chk("early report", early, 1'b0);
		chk("save request", save_n, 1);
		rpt({8'h8F, 8'h26});
		idle();
		$display("test save done");
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge i_core_clk);
		#1;
		i_rst_n = 1'b1;
		@(posedge i_core_clk);
		#1;
		t_port();
		t_datum();
		t_grid();
		t_fix();
		t_save();
		tally_and_finish();
	end

	initial begin
		#2000000;
		err_count++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
